// ===== verilog/ira_consts.svh
// Constants for the indexed register access front end
`ifndef IRA_CONSTS_SVH
`define IRA_CONSTS_SVH

`define IRA_ADDR_POINTER 10'h3E0
`define IRA_ADDR_DATA 10'h3E1
`define IRA_PTR_RESET 8'h00
`define IRA_LOC_LSB 0
`define IRA_LOC_MSB 5
`define IRA_SLOT_BIT 6
`define IRA_CHIP_BIT 7
`define IRA_SLOT_B_OFFSET 8'h40
`define IRA_IDX_REVISION 6'h00
`define IRA_IDX_CTRL_FIRST 6'h01
`define IRA_IDX_CTRL_LAST 6'h07
`define IRA_IDX_IOWIN_FIRST 6'h08
`define IRA_IDX_IOWIN_LAST 6'h0F
`define IRA_IDX_MEM0_BASE 6'h10
`define IRA_IDX_MEM1_BASE 6'h18
`define IRA_IDX_MEM2_BASE 6'h20
`define IRA_MEM_GROUP_LEN 6'h06
`define IRA_IDX_MISC1 6'h16
`define IRA_IDX_WRBUF 6'h17
`define IRA_IDX_MISC2 6'h1E
`define IRA_IDX_CHIPINFO 6'h1F
`define IRA_STORE_DEPTH 128
`define IRA_REVISION_VALUE 8'h5A

`endif

// ===== verilog/ira_pkg.sv
// Types for the indexed register access front end
package ira_pkg;
	typedef enum logic [2:0] {
		IRA_GRP_NONE = 3'h0,
		IRA_GRP_CHIP = 3'h1,
		IRA_GRP_CTRL = 3'h3,
		IRA_GRP_IOWIN = 3'h2,
		IRA_GRP_MEMWIN = 3'h6,
		IRA_GRP_EXT = 3'h7
	} ira_group_t;
endpackage

// ===== verilog/ira_index_decode.sv
// Decoder from an 8-bit pointer to a register group and store slot
`include "ira_consts.svh"
module ira_index_decode
	import ira_pkg::*;
(
	input wire logic [7:0] pointer,
	input wire logic chipId,
	output ira_pkg::ira_group_t group,
	output logic [6:0] storeAddr,
	output logic hit
);
	logic [5:0] loc;
	logic slotB;
	logic chipMatch;
	logic [5:0] memRel;

	always_comb begin
		// Location, slot and chip fields
		loc = pointer[`IRA_LOC_MSB:`IRA_LOC_LSB];
		slotB = pointer[`IRA_SLOT_BIT];
		chipMatch = (pointer[`IRA_CHIP_BIT] == chipId);
		memRel = 6'h00;
		group = IRA_GRP_NONE;
		// Per-slot registers sit 40h higher for slot B
		storeAddr = {slotB, loc};
		if (loc == `IRA_IDX_REVISION) begin
			// One chip-wide copy only
			group = slotB ? IRA_GRP_NONE : IRA_GRP_CHIP;
			storeAddr = {1'b0, loc};
		end else if (loc >= `IRA_IDX_CTRL_FIRST && loc <= `IRA_IDX_CTRL_LAST) begin
			group = IRA_GRP_CTRL;
		end else if (loc >= `IRA_IDX_IOWIN_FIRST && loc <= `IRA_IDX_IOWIN_LAST) begin
			group = IRA_GRP_IOWIN;
		end else if (loc == `IRA_IDX_MISC1 || loc == `IRA_IDX_WRBUF) begin
			group = IRA_GRP_EXT;
		end else if (loc == `IRA_IDX_MISC2 || loc == `IRA_IDX_CHIPINFO) begin
			group = slotB ? IRA_GRP_NONE : IRA_GRP_CHIP;
			storeAddr = {1'b0, loc};
		end else begin
			if (loc >= `IRA_IDX_MEM2_BASE) begin
				memRel = loc - `IRA_IDX_MEM2_BASE;
			end else if (loc >= `IRA_IDX_MEM1_BASE) begin
				memRel = loc - `IRA_IDX_MEM1_BASE;
			end else begin
				memRel = loc - `IRA_IDX_MEM0_BASE;
			end
			if (loc >= `IRA_IDX_MEM0_BASE && memRel < `IRA_MEM_GROUP_LEN) begin
				group = IRA_GRP_MEMWIN;
			end
		end
		hit = chipMatch && (group != IRA_GRP_NONE);
	end
endmodule

// ===== verilog/ira_top.sv
// Pointer and data port pair giving indexed access to internal registers
//
// How it works
// R1: Pointer bits 5:0 pick one of 64 locations per slot.
// R2: Pointer bit 6 picks slot A (0) or slot B (1).
// R3: Pointer bit 7 is chip select; only own chip half answers.
// R4: Data port at 3E1h reads or writes the pointed register.
// R5: Index space has 256 locations, 64 per slot.
// R6: Pointers 00h-3Fh hit slot A, 40h-7Fh hit slot B.
// R7: Pointer reads back on chip 0; chip 1 drives only upper byte.
// R8: Host must avoid reserved locations; they select no register.
// R9: Control and status group at 01h-07h and 41h-47h.
// R10: I/O window address bytes at 08h-0Fh and 48h-4Fh.
// R11: Memory windows 0-2 are six-byte groups at 10h, 18h, 20h.
// R12: Misc control 1 and write buffer control at 16h/17h, 56h/57h.
// R13: Revision, 1Eh and 1Fh exist once per chip, no slot B copy.
// R14: Pointer clears to zero on reset.
// R15: Pointer register decoded at I/O address 3E0h.
// R16: Slot B index equals slot A index plus 40h.
`include "ira_consts.svh"
module ira_top
	import ira_pkg::*;
#(
	parameter int ADDR_W = 10,
	parameter int DEPTH = `IRA_STORE_DEPTH
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic chipId,
	input wire logic [ADDR_W-1:0] ioAddr,
	input wire logic ioRead,
	input wire logic ioWrite,
	input wire logic busWide,
	input wire logic [15:0] ioWrData,
	output logic [15:0] ioRdData,
	output logic ioRdLowEn,
	output logic ioRdHighEn,
	output logic [7:0] pointerOut,
	output ira_pkg::ira_group_t selGroup,
	output logic selHit
);
	import ira_pkg::*;

	// ==========================================
	// Address decode
	logic pointerSel;
	logic dataSel;
	logic wideSel;
	ira_group_t grp;
	logic [6:0] storeAddr;
	logic hit;

	always_comb begin
		// R15: pointer at 3E0h
		pointerSel = (ioAddr == ADDR_W'(`IRA_ADDR_POINTER));
		// R4: data port at 3E1h
		dataSel = (ioAddr == ADDR_W'(`IRA_ADDR_DATA));
		// A 16-bit access at 3E0h covers both ports
		wideSel = pointerSel && busWide;
	end

	// ==========================================
	// Pointer register
	logic [7:0] pointer_reg;
	logic [7:0] pointer_next;

	always_comb begin
		pointer_next = pointer_reg;
		if (ioWrite && pointerSel) begin
			pointer_next = ioWrData[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		// R14: pointer clears on reset
		if (rst) begin
			pointer_reg <= `IRA_PTR_RESET;
		end else begin
			pointer_reg <= pointer_next;
		end
	end

	// ==========================================
	// Index decode
	// R1 R2 R3 R5 R6 R9 R10 R11 R12 R13 R16: location map
	ira_index_decode u_decode (
		.pointer(pointer_reg),
		.chipId(chipId),
		.group(grp),
		.storeAddr(storeAddr),
		.hit(hit)
	);

	// ==========================================
	// Register store
	logic [7:0] store_reg [DEPTH];
	logic dataWr;
	logic [7:0] dataWrByte;

	always_comb begin
		// R8: reserved codes and other chip write nothing
		dataWr = ioWrite && (dataSel || wideSel) && hit && (grp != IRA_GRP_CHIP || storeAddr != 7'h00);
		dataWrByte = wideSel ? ioWrData[15:8] : ioWrData[7:0];
	end

	always_ff @(posedge sys_clk) begin
		// R4: data write goes to pointed register
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				store_reg[i] <= 8'h00;
			end
		end else if (dataWr) begin
			store_reg[storeAddr] <= dataWrByte;
		end
	end

	// ==========================================
	// Read path
	logic [7:0] dataByte;
	logic rdLow;
	logic rdHigh;
	logic [15:0] rdData_next;
	logic [15:0] rdData_reg;

	always_comb begin
		dataByte = 8'h00;
		if (hit) begin
			dataByte = (grp == IRA_GRP_CHIP && storeAddr == 7'h00) ? `IRA_REVISION_VALUE : store_reg[storeAddr];
		end
		// R7: pointer readback only for chip 0
		rdLow = ioRead && ((pointerSel && !chipId) || (dataSel && hit));
		rdHigh = ioRead && wideSel && hit;
		rdData_next = 16'h0000;
		if (pointerSel) begin
			rdData_next = {wideSel ? dataByte : 8'h00, chipId ? 8'h00 : pointer_reg};
		end else if (dataSel) begin
			rdData_next = {8'h00, dataByte};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdData_reg <= 16'h0000;
		end else if (ioRead) begin
			rdData_reg <= rdData_next;
		end
	end

	always_comb begin
		ioRdData = rdData_reg;
		ioRdLowEn = rdLow;
		ioRdHighEn = rdHigh;
		pointerOut = pointer_reg;
		selGroup = grp;
		selHit = hit;
	end
endmodule

// ===== tb/ira_top_props.sv
// Checker on the front end ports
module ira_top_props
	import ira_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic chipId,
	input wire logic [9:0] ioAddr,
	input wire logic ioRead,
	input wire logic ioWrite,
	input wire logic busWide,
	input wire logic ioRdHighEn,
	input wire logic [15:0] ioWrData,
	input wire logic ioRdLowEn,
	input wire logic [7:0] pointerOut,
	input wire ira_pkg::ira_group_t selGroup,
	input wire logic selHit
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire own = pointerOut[7] == chipId;
	wire [5:0] loc = pointerOut[5:0];
	property p_rst; $fell(rst) |-> pointerOut == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_ptr; ioWrite && ioAddr == 10'h3E0 |=> pointerOut == $past(ioWrData[7:0]); endproperty
	a_ptr: assert property (p_ptr) else $error("pointer");
	property p_chip; !own |-> !selHit; endproperty
	a_chip: assert property (p_chip) else $error("chip");
	property p_ctl; own && loc inside {[1:7]} |-> selGroup == IRA_GRP_CTRL; endproperty
	a_ctl: assert property (p_ctl) else $error("ctrl");
	property p_io; own && loc inside {[8:15]} |-> selGroup == IRA_GRP_IOWIN; endproperty
	a_io: assert property (p_io) else $error("io");
	property p_mem; own && loc inside {[16:21], [24:29], [32:37]} |-> selGroup == IRA_GRP_MEMWIN; endproperty
	a_mem: assert property (p_mem) else $error("mem");
	property p_twin; pointerOut[6] && loc inside {0, 30, 31} |-> !selHit; endproperty
	a_twin: assert property (p_twin) else $error("twin");
	property p_low; ioRead && ioAddr == 10'h3E0 |-> ioRdLowEn == !chipId; endproperty
	a_low: assert property (p_low) else $error("lane");
	property p_high; ioRead && busWide && ioAddr == 10'h3E0 |-> ioRdHighEn == selHit; endproperty
	a_high: assert property (p_high) else $error("high lane");
endmodule

// ===== tb/ira_host_model.sv
// Host model driving one-cycle strobes
module ira_host_model (
	input wire logic sys_clk,
	output logic [9:0] ioAddr,
	output logic ioRead,
	output logic ioWrite,
	output logic busWide,
	output logic [15:0] ioWrData
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {ioAddr, ioRead, ioWrite, busWide, ioWrData} = 29'h0;
	task automatic io(input logic w, input logic [9:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		{ioAddr, ioWrite, ioRead, busWide, ioWrData} <= {a, w, !w, a == 10'h3E0 && !w, d};
		@(posedge sys_clk);
		{ioWrite, ioRead, ioWrData} <= {2'h0, ~d};
		#1;
	endtask
endmodule

// ===== tb/ira_top_tb.sv
// Bench for the front end
`define IO u_ira_host_model.io
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module ira_top_tb
	import ira_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'h0, rst = 1'h1, chipId = 1'h0, ioRead, ioWrite, busWide, ioRdLowEn, ioRdHighEn, selHit;
	logic [9:0] ioAddr;
	logic [15:0] ioWrData, ioRdData;
	logic [7:0] pointerOut;
	ira_group_t selGroup;
	int num_errors = 0, n_compared = 0, cyc = 0;
	ira_top u_ira_top (.*);
	ira_host_model u_ira_host_model (.*);
	task automatic t_slots;
		logic [15:0] idx [5] = '{16'h01, 16'h41, 16'h0F, 16'h10, 16'h56};
		for (int k = 0; k < 10; k++) begin
			`IO(1'h1, 10'h3E0, idx[k % 5]);
			`CHK("hit", 1'h1, selHit)
			`IO(k < 5, 10'h3E1, ~idx[k % 5]);
			if (k > 4)
				`CHK("data", ~idx[k % 5][7:0], ioRdData[7:0])
		end
		$display("slots end");
	endtask
	task automatic t_edges;
		`IO(1'h1, 10'h3E0, 16'h005E);
		`CHK("twin", 1'h0, selHit)
		`IO(1'h1, 10'h3E0, 16'h0080);
		`CHK("chip", 1'h0, selHit)
		`IO(1'h1, 10'h3E0, 16'h0041);
		`IO(1'h0, 10'h3E0, 16'h0000);
		`CHK("wide", 16'hBE41, ioRdData)
		`IO(1'h1, 10'h3E0, 16'h0000);
		`IO(1'h1, 10'h3E1, 16'h00FF);
		`IO(1'h0, 10'h3E1, 16'h0000);
		`CHK("rev", 8'h5A, ioRdData[7:0])
		$display("edges end");
	endtask
	task automatic t_chip1;
		@(posedge sys_clk);
		chipId <= 1'h1;
		`IO(1'h1, 10'h3E0, 16'h0081);
		`CHK("own", 1'h1, selHit)
		`IO(1'h0, 10'h3E0, 16'h0000);
		`CHK("chip1", 16'hFE00, ioRdData)
		`IO(1'h1, 10'h3E0, 16'h0001);
		`CHK("other", 1'h0, selHit)
		@(posedge sys_clk);
		chipId <= 1'h0;
		$display("chip1 end");
	endtask
	task automatic conclude;
		$display("%0d compared %0d mismatches", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial forever #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'h0;
		#1;
		`CHK("reset", 8'h00, pointerOut)
		t_slots();
		t_edges();
		t_chip1();
		conclude();
	end
endmodule
bind ira_top ira_top_props u_ira_top_props (.*);
